// ===== src/status_display_pkg.sv
package status_display_pkg;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS      = 8'h00;
   localparam logic [7:0] EVENT_OFS     = 8'h04;
   localparam logic [7:0] DIAG_OFS      = 8'h08;
   localparam logic [7:0] LEVEL_OFS     = 8'h0c;
   localparam logic [7:0] PAIR_OFS      = 8'h10;
   localparam logic [7:0] STATUS_OFS    = 8'h14;
   localparam logic [7:0] SLOT_OFS      = 8'h18;

   // Control register fields
   localparam int CTRL_CONFIGURED_BIT = 0;
   localparam int CTRL_BOOT_DONE_BIT  = 1;
   localparam int CTRL_DISP_OFF_BIT   = 2;
   localparam int CTRL_ROTATE_BIT     = 3;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

   // Event register fields (write one to raise)
   localparam int EV_AWAIT_BIT     = 0;
   localparam int EV_XFER_BIT      = 1;
   localparam int EV_CONFIRM_BIT   = 2;
   localparam int EV_PING_BIT      = 3;
   localparam int EV_FIELD_OCC_BIT = 4;
   localparam int EV_FIELD_FREE_BIT= 5;

   // Diagnostic register fields
   localparam int DIAG_CODE_LSB   = 0;
   localparam int DIAG_CODE_W     = 12;
   localparam int DIAG_CAT_LSB    = 12;
   localparam int DIAG_SRC_BIT    = 15;
   localparam int DIAG_BLOCK_BIT  = 16;

   // Diagnostic category letters
   localparam logic [7:0] CAT_FAILURE  = 8'h46;
   localparam logic [7:0] CAT_EXTERNAL = 8'h45;
   localparam logic [7:0] CAT_USAGE    = 8'h55;
   localparam logic [7:0] CAT_INFO     = 8'h49;
   localparam logic [7:0] CAT_PARAM    = 8'h50;

   // Timing
   localparam int CLK_HZ          = 40_000_000;
   localparam int RECOVER_S       = 10;
   localparam int FIELD_FREE_S    = 5;
   localparam int RECOVER_CYCLES  = RECOVER_S * CLK_HZ;
   localparam int FREE_CYCLES     = FIELD_FREE_S * CLK_HZ;
   localparam int ITEM_MS         = 1000;
   localparam int ITEM_CYCLES     = (ITEM_MS * (CLK_HZ / 1000));

   localparam int CHARS = 24;

   // Screen content selector
   typedef enum logic [3:0] {
      SCR_TYPE       = 4'h0,
      SCR_SERIAL     = 4'h1,
      SCR_NAME       = 4'h2,
      SCR_SETUP_REQ  = 4'h3,
      SCR_IP         = 4'h4,
      SCR_WIRELESS   = 4'h5,
      SCR_DATE       = 4'h6,
      SCR_SIGNATURE  = 4'h7,
      SCR_LEVEL      = 4'h8,
      SCR_PAIR       = 4'h9,
      SCR_WAIT_SETUP = 4'ha,
      SCR_XFER       = 4'hb,
      SCR_PING       = 4'hc,
      SCR_DIAG       = 4'hd,
      SCR_BLANK      = 4'he
   } screen_type;

   // Top state, Gray along boot -> run -> message
   typedef enum logic [2:0] {
      ST_BOOT    = 3'b000,
      ST_RUN     = 3'b001,
      ST_MESSAGE = 3'b011,
      ST_LOCKED  = 3'b010,
      ST_SETUP   = 3'b110
   } state_type;

endpackage : status_display_pkg

// ===== src/status_display_sequencer.sv
//
// Operation
// - Unconfigured power-up cycles type, serial, name and setup-required screens.
// - The start-up cycle repeats until boot ends, then unconfigured shows level permanently.
// - Configured power-up cycles type, serial, name, IP, wireless, date, signature and level.
// - Normal operation shows the monitored field pair on the 24-character display.
// - During setup transfer the waiting screen stands until the download is confirmed.
// - While data actually moves the transfer screen replaces the waiting screen.
// - A network ping in normal operation shows a ping screen for one dwell period.
// - Messages show their source, protective function or device, followed by a code.
// - Each diagnostic carries one of five category letters F, E, U, I or P.
// - A diagnostic shows its category letter first, then the numeric code.
// - Non-locking errors recover automatically after 10 s without restarting outputs.
// - A blocking error locks the display state until power is removed.
// - After the protective field stays free about 5 s the normal screen returns.
// - Normal content follows operating state and honours display-off and rotation settings.
// - The level screen shows signed horizontal and vertical values with axis letters.
`timescale 1ns/1ps
`default_nettype none
module status_display_sequencer #(
   parameter int RECOVER_COUNT = status_display_pkg::RECOVER_CYCLES,
   parameter int FREE_COUNT    = status_display_pkg::FREE_CYCLES,
   parameter int ITEM_COUNT    = status_display_pkg::ITEM_CYCLES
) (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst,
   // Avalon-MM slave
   input  wire logic [7:0]                     address,
   input  wire logic                           read,
   input  wire logic                           write,
   input  wire logic [31:0]                    writedata,
   input  wire logic [3:0]                     byteenable,
   output logic [31:0]                         readdata,
   output logic                                waitrequest,
   // Display module
   input  wire logic [4:0]                     char_index,
   output logic [7:0]                          char_code,
   output status_display_pkg::screen_type      screen_reg,
   // Output restart guard
   output logic                                restart_inhibit
);
   import status_display_pkg::*;

   logic [31:0] ctrl_reg;
   logic [16:0] diag_reg;
   logic [15:0] level_reg;
   logic [7:0]  pair_reg;
   state_type   state_reg;
   state_type   state_next;
   screen_type  screen_next;
   logic [3:0]  slot_reg;
   logic [31:0] item_cnt_reg;
   logic [31:0] recover_cnt_reg;
   logic [31:0] free_cnt_reg;
   logic        xfer_reg;
   logic        ping_reg;
   logic        field_free_reg;
   logic        diag_pending_reg;
   logic        ack_reg;
   logic        wr_ev;
   logic        wr_diag;
   logic        item_tick;
   logic        recover_done;
   logic        free_done;
   logic        configured;
   logic        valid_cat;

   // One wait state on every access, then the answer at the following edge
   assign waitrequest = (read | write) & ~ack_reg;
   assign wr_ev       = write & ack_reg & (address == EVENT_OFS);
   assign wr_diag     = write & ack_reg & (address == DIAG_OFS);
   assign configured  = ctrl_reg[CTRL_CONFIGURED_BIT];

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
      end else begin
         ack_reg <= (read | write) & ~ack_reg;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_reg  <= CTRL_RESET;
         level_reg <= 16'h0000;
         pair_reg  <= 8'h00;
      end else if (write & ack_reg) begin
         case (address)
            CTRL_OFS:  if (byteenable[0]) ctrl_reg[7:0] <= writedata[7:0];
            LEVEL_OFS: begin
               if (byteenable[0]) level_reg[7:0]  <= writedata[7:0];
               if (byteenable[1]) level_reg[15:8] <= writedata[15:8];
            end
            PAIR_OFS:  if (byteenable[0]) pair_reg <= writedata[7:0];
            default: ;
         endcase
      end
   end

   always_comb begin
      case (address)
         CTRL_OFS:   readdata = ctrl_reg;
         DIAG_OFS:   readdata = {15'h0000, diag_reg};
         LEVEL_OFS:  readdata = {16'h0000, level_reg};
         PAIR_OFS:   readdata = {24'h000000, pair_reg};
         STATUS_OFS: readdata = {24'h000000, 2'b00, diag_pending_reg, xfer_reg,
                                 ping_reg, state_reg};
         SLOT_OFS:   readdata = {24'h000000, slot_reg, screen_reg};
         default:    readdata = 32'h0000_0000;
      endcase
   end

   always_comb begin
      case (writedata[DIAG_CAT_LSB +: 3])
         3'h0, 3'h1, 3'h2, 3'h3, 3'h4: valid_cat = 1'b1;
         default: valid_cat = 1'b0;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         diag_reg         <= 17'h00000;
         diag_pending_reg <= 1'b0;
      end else if (wr_diag && valid_cat && state_reg != ST_LOCKED) begin
         diag_reg         <= writedata[16:0];
         diag_pending_reg <= 1'b1;
      end else if (recover_done || free_done) begin
         diag_pending_reg <= diag_reg[DIAG_BLOCK_BIT];
      end
   end

   // transfer and ping flags; raise wins over clear
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         xfer_reg <= 1'b0;
         ping_reg <= 1'b0;
      end else begin
         if (wr_ev && writedata[EV_XFER_BIT]) xfer_reg <= 1'b1;
         else if (wr_ev && (writedata[EV_CONFIRM_BIT] || writedata[EV_AWAIT_BIT])) xfer_reg <= 1'b0;
         if (wr_ev && writedata[EV_PING_BIT]) ping_reg <= 1'b1;
         else if (item_tick) ping_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         field_free_reg <= 1'b1;
      end else if (wr_ev && writedata[EV_FIELD_OCC_BIT]) begin
         field_free_reg <= 1'b0;
      end else if (wr_ev && writedata[EV_FIELD_FREE_BIT]) begin
         field_free_reg <= 1'b1;
      end
   end

   // Screen dwell timer
   assign item_tick = (item_cnt_reg == 32'(ITEM_COUNT - 1));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         item_cnt_reg <= 32'h0000_0000;
      end else begin
         item_cnt_reg <= (item_tick | (wr_ev & writedata[EV_PING_BIT])) ? 32'h0
                         : item_cnt_reg + 32'h1;
      end
   end

   assign recover_done = (state_reg == ST_MESSAGE) && !diag_reg[DIAG_BLOCK_BIT]
                         && (recover_cnt_reg == 32'(RECOVER_COUNT - 1));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         recover_cnt_reg <= 32'h0000_0000;
      end else if (state_reg != ST_MESSAGE || wr_diag || recover_done) begin
         recover_cnt_reg <= 32'h0000_0000;
      end else begin
         recover_cnt_reg <= recover_cnt_reg + 32'h0000_0001;
      end
   end

   assign free_done = (state_reg == ST_MESSAGE) && !diag_reg[DIAG_BLOCK_BIT]
                      && (free_cnt_reg == 32'(FREE_COUNT - 1));
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         free_cnt_reg <= 32'h0000_0000;
      end else if (!field_free_reg || state_reg != ST_MESSAGE || free_done) begin
         free_cnt_reg <= 32'h0000_0000;
      end else begin
         free_cnt_reg <= free_cnt_reg + 32'h0000_0001;
      end
   end

   // outputs stay inhibited until an explicit restart
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         restart_inhibit <= 1'b1;
      end else if (diag_pending_reg) begin
         restart_inhibit <= 1'b1;
      end else if (wr_ev && writedata[EV_FIELD_FREE_BIT] && state_reg == ST_RUN) begin
         restart_inhibit <= 1'b0;
      end
   end

   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_BOOT:    if (ctrl_reg[CTRL_BOOT_DONE_BIT] && configured) state_next = ST_RUN;
         ST_RUN: begin
            if (diag_pending_reg) state_next = ST_MESSAGE;
            else if (xfer_reg || (wr_ev && writedata[EV_AWAIT_BIT])) state_next = ST_SETUP;
         end
         ST_SETUP: begin
            if (wr_ev && writedata[EV_CONFIRM_BIT]) state_next = ST_RUN;
            else if (diag_pending_reg) state_next = ST_MESSAGE;
         end
         ST_MESSAGE: begin
            if (diag_reg[DIAG_BLOCK_BIT]) state_next = ST_LOCKED;
            else if (recover_done || free_done) state_next = ST_RUN;
         end
         ST_LOCKED:  state_next = ST_LOCKED;
         default:    state_next = ST_BOOT;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_reg <= ST_BOOT;
      end else begin
         state_reg <= state_next;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         slot_reg <= 4'h0;
      end else if (state_reg == ST_BOOT && item_tick) begin
         if (configured) slot_reg <= (slot_reg == 4'h7) ? 4'h0 : slot_reg + 4'h1;
         else slot_reg <= (slot_reg == 4'h3) ? 4'h0 : slot_reg + 4'h1;
      end
   end

   always_comb begin
      screen_next = SCR_PAIR;
      case (state_reg)
         ST_BOOT: begin
            if (!configured && ctrl_reg[CTRL_BOOT_DONE_BIT]) begin
               // level stands once boot has ended
               screen_next = SCR_LEVEL;
            end else if (configured) begin
               screen_next = (slot_reg == 4'h7) ? SCR_LEVEL : screen_type'(slot_reg);
               if (slot_reg == 4'h3) screen_next = SCR_IP;
               else if (slot_reg >= 4'h4 && slot_reg < 4'h7)
                  screen_next = screen_type'(slot_reg + 4'h1);
            end else begin
               screen_next = screen_type'(slot_reg);
            end
         end
         ST_SETUP:   screen_next = xfer_reg ? SCR_XFER : SCR_WAIT_SETUP;
         ST_MESSAGE: screen_next = SCR_DIAG;
         ST_LOCKED:  screen_next = SCR_DIAG;
         ST_RUN:     screen_next = ping_reg ? SCR_PING : SCR_PAIR;
         default:    screen_next = SCR_BLANK;
      endcase
      if (ctrl_reg[CTRL_DISP_OFF_BIT] && state_reg == ST_RUN && !ping_reg)
         screen_next = SCR_BLANK;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         screen_reg <= SCR_TYPE;
      end else begin
         screen_reg <= screen_next;
      end
   end

   logic [7:0] cat_letter;
   always_comb begin
      case (diag_reg[DIAG_CAT_LSB +: 3])
         3'h0: cat_letter = CAT_FAILURE;
         3'h1: cat_letter = CAT_EXTERNAL;
         3'h2: cat_letter = CAT_USAGE;
         3'h3: cat_letter = CAT_INFO;
         default: cat_letter = CAT_PARAM;
      endcase
   end

   text_composer u_text (
      .clk        (clk),
      .rst        (rst),
      .screen     (screen_reg),
      .rotate     (ctrl_reg[CTRL_ROTATE_BIT]),
      .cat_letter (cat_letter),
      .src_device (diag_reg[DIAG_SRC_BIT]),
      .code       (diag_reg[DIAG_CODE_LSB +: DIAG_CODE_W]),
      .level_h    (level_reg[15:8]),
      .level_v    (level_reg[7:0]),
      .pair_id    (pair_reg),
      .char_index (char_index),
      .char_code  (char_code)
   );

endmodule : status_display_sequencer
`default_nettype wire

// ===== src/text_composer.sv
`timescale 1ns/1ps
`default_nettype none
module text_composer (
   // Clock and reset
   input  wire logic                           clk,
   input  wire logic                           rst,
   // Selection
   input  wire status_display_pkg::screen_type screen,
   input  wire logic                           rotate,
   input  wire logic [7:0]                     cat_letter,
   input  wire logic                           src_device,
   input  wire logic [11:0]                    code,
   input  wire logic signed [7:0]              level_h,
   input  wire logic signed [7:0]              level_v,
   input  wire logic [7:0]                     pair_id,
   // Character output
   input  wire logic [4:0]                     char_index,
   output logic [7:0]                          char_code
);
   import status_display_pkg::*;

   logic [7:0] pos;
   logic [7:0] ch;

   function automatic logic [7:0] hexd(input logic [3:0] n);
      hexd = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
   endfunction : hexd

   function automatic logic [7:0] sgn(input logic signed [7:0] v);
      sgn = v[7] ? 8'h2d : 8'h2b;
   endfunction : sgn

   function automatic logic [7:0] mag(input logic signed [7:0] v);
      mag = v[7] ? 8'(-v) : v;
   endfunction : mag

   // Rotation reverses character order on the glass
   always_comb begin
      pos = rotate ? 8'(CHARS - 1 - int'(char_index)) : {3'h0, char_index};
      ch  = 8'h20;
      case (screen)
         SCR_SETUP_REQ:  if (pos == 8'h0) ch = 8'h43; else if (pos == 8'h1) ch = 8'h52;
         SCR_WAIT_SETUP: if (pos == 8'h0) ch = 8'h41; else if (pos == 8'h1) ch = 8'h43;
         SCR_XFER:       if (pos == 8'h0) ch = 8'h44; else if (pos == 8'h1) ch = 8'h43;
         SCR_PING:       if (pos == 8'h0) ch = 8'h50; else if (pos == 8'h1) ch = 8'h52;
         SCR_PAIR: begin
            if (pos == 8'h0) ch = 8'h41;
            else if (pos == 8'h1) ch = hexd(pair_id[7:4]);
            else if (pos == 8'h2) ch = hexd(pair_id[3:0]);
         end
         SCR_LEVEL: begin
            case (pos)
               8'h0: ch = 8'h48;
               8'h1: ch = sgn(level_h);
               8'h2: ch = hexd(4'(mag(level_h) >> 4));
               8'h3: ch = hexd(4'(mag(level_h)));
               8'h5: ch = 8'h56;
               8'h6: ch = sgn(level_v);
               8'h7: ch = hexd(4'(mag(level_v) >> 4));
               8'h8: ch = hexd(4'(mag(level_v)));
               default: ch = 8'h20;
            endcase
         end
         SCR_DIAG: begin
            case (pos)
               8'h0: ch = src_device ? 8'h44 : 8'h50;
               8'h1: ch = src_device ? 8'h20 : 8'h41;
               8'h2: ch = 8'h3a;
               8'h3: ch = cat_letter;
               8'h4: ch = hexd(code[11:8]);
               8'h5: ch = hexd(code[7:4]);
               8'h6: ch = hexd(code[3:0]);
               default: ch = 8'h20;
            endcase
         end
         SCR_BLANK: ch = 8'h20;
         default: if (pos == 8'h0) ch = 8'h30 + {4'h0, screen};
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         char_code <= 8'h20;
      end else begin
         char_code <= ch;
      end
   end

endmodule : text_composer
`default_nettype wire

// ===== test/display_model.sv
`timescale 1ns/1ps
`default_nettype none
module display_model (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // Character port
   input  wire logic [7:0]   char_code,
   output logic [4:0]        char_index,
   // Collected line, position i at bits i*8
   output logic [191:0]      line_text
);
   import status_display_pkg::*;
   logic [4:0] idx_d1;
   logic       fill;
   // scan 24 positions; a character arrives one cycle after its index
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         char_index <= 5'h00;
         idx_d1     <= 5'h00;
         fill       <= 1'b0;
         line_text  <= 192'h0;
      end else begin
         char_index <= (char_index == 5'(CHARS - 1)) ? 5'h00 : char_index + 5'h01;
         idx_d1     <= char_index;
         fill       <= 1'b1;
         if (fill) line_text[idx_d1*8 +: 8] <= char_code;
      end
   end
endmodule : display_model
`default_nettype wire

// ===== test/status_display_sva.sv
`timescale 1ns/1ps
`default_nettype none
module status_display_sva #(
   parameter int RECOVER_COUNT = status_display_pkg::RECOVER_CYCLES,
   parameter int FREE_COUNT    = status_display_pkg::FREE_CYCLES,
   parameter int ITEM_COUNT    = status_display_pkg::ITEM_CYCLES
) (
   // Clock and reset
   input wire logic                           clk,
   input wire logic                           rst,
   // Register bus
   input wire logic [7:0]                     address,
   input wire logic                           read,
   input wire logic                           write,
   input wire logic [31:0]                    writedata,
   input wire logic [31:0]                    readdata,
   input wire logic                           waitrequest,
   // Display state
   input wire status_display_pkg::screen_type screen_reg,
   input wire logic                           restart_inhibit
);
   import status_display_pkg::*;
   logic        taken;
   logic        diag_take;
   logic        ping_take;
   logic        free_take;
   logic        locked_q;
   int unsigned diag_cnt;
   assign taken     = write && !waitrequest;
   assign diag_take = taken && address == DIAG_OFS && writedata[14:12] <= 3'h4;
   assign ping_take = taken && address == EVENT_OFS && writedata[EV_PING_BIT];
   assign free_take = taken && address == EVENT_OFS && writedata[EV_FIELD_FREE_BIT];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) locked_q <= 1'b0;
      else if (diag_take && writedata[DIAG_BLOCK_BIT]) locked_q <= 1'b1;
   end
   // A fresh diagnostic restarts the count, so a run of messages is not one long wait
   always_ff @(posedge clk or posedge rst) begin
      if (rst) diag_cnt <= 0;
      else if (diag_take || screen_reg != SCR_DIAG || locked_q) diag_cnt <= 0;
      else diag_cnt <= diag_cnt + 1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   wait_state_a: assert property ((read || write) && !$past(read || write)
      |-> waitrequest ##1 !waitrequest) else $error("wait state wrong");
   idle_ready_a: assert property (!(read || write) |-> !waitrequest)
      else $error("waitrequest high while idle");
   unmapped_read_a: assert property (read && !waitrequest && address > SLOT_OFS
      |-> readdata == 32'h0) else $error("unmapped read not zero");
   reset_screen_a: assert property ($past(rst) |-> screen_reg == SCR_TYPE && restart_inhibit)
      else $error("reset screen wrong");
   diag_show_a: assert property (diag_take && !locked_q |-> ##[1:3] screen_reg == SCR_DIAG)
      else $error("diagnostic not shown");
   diag_inhibit_a: assert property (screen_reg == SCR_DIAG |-> restart_inhibit)
      else $error("restart allowed during message");
   recover_bound_a: assert property (diag_cnt <= RECOVER_COUNT + 4)
      else $error("message outlived recovery time");
   inhibit_clear_a: assert property ($fell(restart_inhibit)
      |-> $past(free_take) || $past(free_take, 2)) else $error("restart guard cleared without cause");
   ping_show_a: assert property (ping_take && screen_reg == SCR_PAIR
      |-> ##[1:3] screen_reg == SCR_PING) else $error("ping screen not shown");
   lock_hold_a: assert property ($past(locked_q, 2) |-> screen_reg == SCR_DIAG)
      else $error("blocking error left display");
   cover property (screen_reg == SCR_XFER);
   cover property (ping_take);
   cover property (locked_q);
endmodule : status_display_sva
bind status_display_sequencer status_display_sva #(.RECOVER_COUNT(RECOVER_COUNT),
   .FREE_COUNT(FREE_COUNT), .ITEM_COUNT(ITEM_COUNT)) chk (.clk(clk), .rst(rst),
   .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
   .waitrequest(waitrequest), .screen_reg(screen_reg), .restart_inhibit(restart_inhibit));
`default_nettype wire

// ===== test/tb_status_display_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
module tb_status_display_sequencer;
   import status_display_pkg::*;
   localparam int REC = 100;
   localparam int FREE = 10;
   logic clk, rst, read, write, waitrequest, restart_inhibit;
   logic [7:0] address, char_code;
   logic [31:0] writedata, readdata, q;
   logic [3:0] byteenable;
   logic [4:0] char_index;
   logic [191:0] line_text;
   screen_type screen_reg;
   int fails, total_checks;
   logic [7:0] lt [5] = '{CAT_FAILURE, CAT_EXTERNAL, CAT_USAGE, CAT_INFO, CAT_PARAM};
   status_display_sequencer #(.RECOVER_COUNT(REC), .FREE_COUNT(FREE), .ITEM_COUNT(5)) uut (
      .clk(clk), .rst(rst), .address(address), .read(read), .write(write),
      .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest), .char_index(char_index), .char_code(char_code),
      .screen_reg(screen_reg), .restart_inhibit(restart_inhibit));
   display_model disp (.clk(clk), .rst(rst), .char_code(char_code), .char_index(char_index),
      .line_text(line_text));
   always #12.5 clk = ~clk;
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   // Request held until the edge that samples waitrequest low
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      address   <= a;
      writedata <= d;
      read      <= !wr;
      write     <= wr;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 50);
      check("bus answer", waitrequest, 1'b0);
      q = readdata;
      read  <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic scr(input string what, input int n, input screen_type e);
      repeat (n) @(posedge clk);
      @(negedge clk);
      check(what, screen_reg, e);
   endtask : scr
   function automatic logic [5:0] pos(input logic [7:0] c);
      pos = 6'h3f;
      for (int j = 23; j >= 0; j--) if (line_text[j*8 +: 8] === c) pos = 6'(j);
   endfunction : pos
   function automatic logic lead(input logic [7:0] c);
      logic [7:0] nx;
      lead = 1'b0;
      for (int j = 0; j < 23; j++) begin
         nx = line_text[j*8+8 +: 8];
         if (line_text[j*8 +: 8] === c && nx >= 8'h30 && nx <= 8'h39) lead = 1'b1;
      end
   endfunction : lead
   task automatic seq(input string what, input int n, input int cnt, input logic [63:0] exp);
      logic [63:0] got;
      screen_type last;
      int k;
      got = 64'h0;
      k = 0;
      last = SCR_BLANK;
      repeat (n) begin
         @(negedge clk);
         if (screen_reg !== last && k < cnt) begin
            got[4*k +: 4] = screen_reg;
            k++;
         end
         last = screen_reg;
      end
      check(what, got, exp);
   endtask : seq
   task automatic reset_dut;
      @(posedge clk);
      rst <= 1'b1;
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      check("start screen", screen_reg, SCR_TYPE);
      check("guard at reset", restart_inhibit, 1'b1);
   endtask : reset_dut
   task automatic t_unconf;
      seq("unconfigured cycle", 32, 6, 64'h103210);
      bus(1, CTRL_OFS, 32'h2);
      scr("level after boot", 3, SCR_LEVEL);
      bus(1, LEVEL_OFS, 32'hfd09);
      repeat (30) @(posedge clk);
      check("axis order", pos(8'h48) < pos(8'h56) && pos(8'h56) != 6'h3f, 1'b1);
      check("minus sign", pos(8'h2d) != 6'h3f, 1'b1);
      check("digit nine", pos(8'h39) != 6'h3f, 1'b1);
   endtask : t_unconf
   task automatic t_conf;
      bus(1, CTRL_OFS, 32'h1);
      seq("configured cycle", 44, 9, 64'h087654210);
      bus(1, CTRL_OFS, 32'h3);
      scr("pair screen", 3, SCR_PAIR);
      bus(1, 8'h40, 32'hff);
      bus(0, CTRL_OFS, 32'h0);
      check("control readback", q, 32'h3);
      bus(0, 8'h40, 32'h0);
      check("unmapped read", q, 32'h0);
      bus(1, EVENT_OFS, 32'h20);
      scr("pair kept", 2, SCR_PAIR);
      check("guard released", restart_inhibit, 1'b0);
   endtask : t_conf
   task automatic t_events;
      bus(1, EVENT_OFS, 32'h1);
      scr("waiting screen", 2, SCR_WAIT_SETUP);
      bus(1, EVENT_OFS, 32'h6);
      scr("transfer screen", 2, SCR_XFER);
      bus(1, EVENT_OFS, 32'h4);
      scr("confirmed", 2, SCR_PAIR);
      bus(1, EVENT_OFS, 32'h8);
      scr("ping screen", 2, SCR_PING);
      scr("ping over", 10, SCR_PAIR);
      bus(1, CTRL_OFS, 32'h7);
      scr("display off", 2, SCR_BLANK);
      bus(1, CTRL_OFS, 32'hb);
      scr("rotated", 2, SCR_PAIR);
      repeat (30) @(posedge clk);
      check("rotated", pos(8'h41), 6'h17);
      bus(1, CTRL_OFS, 32'h3);
   endtask : t_events
   task automatic t_diag;
      bus(1, EVENT_OFS, 32'h10);
      for (int c = 0; c < 5; c++) begin
         bus(1, DIAG_OFS, {16'h0, c[0], c[2:0], 12'h007});
         scr("diag screen", 2, SCR_DIAG);
         repeat (30) @(posedge clk);
         check("letter then code", lead(lt[c]), 1'b1);
      end
      scr("auto recovered", REC, SCR_PAIR);
      check("guard held", restart_inhibit, 1'b1);
      bus(1, EVENT_OFS, 32'h20);
      scr("still pair", 2, SCR_PAIR);
      check("guard free", restart_inhibit, 1'b0);
      bus(1, DIAG_OFS, 32'h1007);
      bus(1, EVENT_OFS, 32'h10);
      bus(1, EVENT_OFS, 32'h20);
      scr("message held", FREE - 4, SCR_DIAG);
      scr("field free return", 8, SCR_PAIR);
      bus(1, DIAG_OFS, 32'h5007);
      scr("bad category", 3, SCR_PAIR);
   endtask : t_diag
   task automatic t_lock;
      bus(1, DIAG_OFS, 32'h10007);
      scr("locked screen", 2, SCR_DIAG);
      bus(1, EVENT_OFS, 32'h20);
      scr("no recovery", REC + 10, SCR_DIAG);
      bus(0, STATUS_OFS, 32'h0);
      check("locked state", q[2:0], ST_LOCKED);
      reset_dut();
   endtask : t_lock
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      address = 8'h00;
      read = 1'b0;
      write = 1'b0;
      writedata = 32'h0;
      byteenable = 4'hf;
      fails = 0;
      total_checks = 0;
      reset_dut();
      t_unconf();
      reset_dut();
      t_conf();
      t_events();
      t_diag();
      t_lock();
      test_done();
   end
   initial begin
      repeat (20000) @(posedge clk);
      fails++;
      test_done();
   end
endmodule : tb_status_display_sequencer
`default_nettype wire
